/* rtl/mdq_engine.sv */
// memory deque engine: queue transfer service and queue instructions
// What this block does
// - size mask is block length minus one, K low ones.
// - block start is pointer AND NOT mask, end is pointer OR mask.
// - control block words: read ptr, write ptr, segment/extension, mask.
// - read pointer names head datum; write pointer names cell past tail.
// - third word gives six extension bits or a segment number.
// - equal pointers mean empty; full leaves one slot unused.
// - input appends word at bottom if room, else end-of-range.
// - output delivers head word, or zero word with end-of-range if empty.
// - the word that empties the queue carries no end-of-range.
// - all queue memory accesses bypass the cache.
// - transfer requests find the control block at peripheral address, segment zero.
// - instructions take block address from pointer word, data via accumulator.
// - instructions do no wait or notify, only queue and codes.
// - five operations: add top, add bottom, remove top, remove bottom, test.
// - physical queues need ring zero; ring governs block access rights.
// - remove top reads two pointers first, exits early when empty.
// - add bottom reads four words, exits full when next equals read.
// - datum is written before the write pointer is updated.
// - remove bottom steps write pointer back, loads cell, stores pointer.
// - test computes occupancy and compares against zero and mask.
`timescale 1ns/100ps
`include "mdq_defs.svh"

module mdq_engine (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        srst_i,
  // peripheral direct transfer request
  input  wire logic        direct_transfer_request_i,
  input  wire logic [4:0]  request_mode_code_i,
  input  wire logic [15:0] peripheral_address_bus_i,
  input  wire logic [15:0] xfer_wdata_i,
  output logic             xfer_ack_o,
  // peripheral output words, bit 16 is end-of-range
  output logic             out_valid_o,
  input  wire logic        out_ready_i,
  output logic      [15:0] out_data_o,
  output logic             out_end_of_range_signal_o,
  output logic             in_end_of_range_signal_o,
  // queue instruction request
  input  wire logic        op_valid_i,
  input  wire logic [2:0]  op_code_i,
  input  wire logic [15:0] argument_pointer_word_i,
  input  wire logic [11:0] op_segment_i,
  input  wire logic        op_physical_i,
  input  wire logic [1:0]  ring_i,
  input  wire logic [15:0] acc_i,
  output logic             op_done_o,
  output logic      [15:0] acc_o,
  output logic      [2:0]  cond_code_o,
  // main memory port, uncached
  output logic             mem_req_o,
  output logic             mem_we_o,
  output logic      [27:0] mem_addr_o,
  output logic      [15:0] mem_wdata_o,
  output logic             mem_uncached_o,
  output logic      [1:0]  mem_ring_o,
  input  wire logic        mem_ack_i,
  input  wire logic [15:0] mem_rdata_i
);

  mdq_pkg::mdq_state_e state_reg;
  mdq_pkg::mdq_op_e    op_reg;
  logic        xfer_reg;
  logic        phys_reg;
  logic [11:0] cb_seg_reg;
  logic [15:0] cb_addr_reg;
  logic [15:0] top_reg;
  logic [15:0] bot_reg;
  logic [15:0] seg_reg;
  logic [15:0] mask_reg;
  logic [15:0] data_reg;
  logic [15:0] new_ptr_reg;
  logic        eor_reg;
  logic [2:0]  cc_reg;
  logic [15:0] top_inc;
  logic [15:0] top_dec;
  logic [15:0] bot_inc;
  logic [15:0] bot_dec;
  logic        q_empty;
  logic        q_full;
  logic [15:0] q_len;
  logic        buf_in_ready;
  logic        buf_in_valid;
  logic [16:0] buf_out_data;
  logic        in_req;
  logic        out_req;
  logic        mem_wait;
  logic        op_req;

  // --------------------------------------------------------------------------
  // pointer arithmetic and output buffer
  // --------------------------------------------------------------------------
  mdq_ptr_calc u_ptr (
    .top_i     (top_reg),
    .bottom_i  (bot_reg),
    .mask_i    (mask_reg),
    .top_inc_o (top_inc),
    .top_dec_o (top_dec),
    .bot_inc_o (bot_inc),
    .bot_dec_o (bot_dec),
    .origin_o  (),
    .end_o     (),
    .empty_o   (q_empty),
    .full_o    (q_full),
    .length_o  (q_len)
  );

  mdq_skid_buf u_buf (
    .mclk_i      (mclk_i),
    .srst_i      (srst_i),
    .in_valid_i  (buf_in_valid),
    .in_ready_o  (buf_in_ready),
    .in_data_i   ({eor_reg, data_reg}),
    .out_valid_o (out_valid_o),
    .out_ready_i (out_ready_i),
    .out_data_o  (buf_out_data)
  );

  assign out_data_o                = buf_out_data[15:0];
  assign out_end_of_range_signal_o = buf_out_data[16];

  // request decode; an output request waits for buffer room
  // a requester still holds its request on the edge that shows the answer; skip that edge
  assign in_req  = direct_transfer_request_i && (request_mode_code_i == `MDQ_MODE_IN)
                   && !xfer_ack_o && !op_done_o;
  assign out_req = direct_transfer_request_i && (request_mode_code_i == `MDQ_MODE_OUT)
                   && buf_in_ready && !xfer_ack_o && !op_done_o;
  assign op_req  = op_valid_i && !xfer_ack_o && !op_done_o;
  assign buf_in_valid = (state_reg == mdq_pkg::MDQ_ST_DONE) && xfer_reg && !op_is_add(op_reg);
  assign mem_wait     = mem_req_o && !mem_ack_i;

  // adds are the two insert operations
  function automatic logic op_is_add(input mdq_pkg::mdq_op_e op);
    return (op == mdq_pkg::MDQ_OP_ADD_TOP) || (op == mdq_pkg::MDQ_OP_ADD_BOTTOM);
  endfunction

  // --------------------------------------------------------------------------
  // sequencer; one control block sequence at a time
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      state_reg <= mdq_pkg::MDQ_ST_IDLE;
    end else if (!mem_wait) begin
      unique case (state_reg)
        mdq_pkg::MDQ_ST_IDLE: begin
          if (in_req || out_req) begin
            state_reg <= mdq_pkg::MDQ_ST_RTOP;
          end else if (op_req) begin
            if (op_physical_i && ring_i != `MDQ_RING_PRIV) begin
              state_reg <= mdq_pkg::MDQ_ST_EXIT;
            end else begin
              state_reg <= mdq_pkg::MDQ_ST_RTOP;
            end
          end
        end
        mdq_pkg::MDQ_ST_RTOP:  state_reg <= mdq_pkg::MDQ_ST_RBOT;
        mdq_pkg::MDQ_ST_RBOT: begin
          // removals and test bail out after two reads when empty
          if (!op_is_add(op_reg) && mem_rdata_i == top_reg) begin
            state_reg <= mdq_pkg::MDQ_ST_DONE;
          end else begin
            state_reg <= mdq_pkg::MDQ_ST_RSEG;
          end
        end
        mdq_pkg::MDQ_ST_RSEG:  state_reg <= mdq_pkg::MDQ_ST_RMASK;
        mdq_pkg::MDQ_ST_RMASK: begin
          if (op_reg == mdq_pkg::MDQ_OP_TEST) begin
            state_reg <= mdq_pkg::MDQ_ST_DONE;
          end else begin
            state_reg <= mdq_pkg::MDQ_ST_DATA;
          end
        end
        mdq_pkg::MDQ_ST_DATA: begin
          if (eor_reg) begin
            state_reg <= mdq_pkg::MDQ_ST_DONE;
          end else begin
            state_reg <= mdq_pkg::MDQ_ST_WPTR;
          end
        end
        mdq_pkg::MDQ_ST_WPTR:  state_reg <= mdq_pkg::MDQ_ST_DONE;
        mdq_pkg::MDQ_ST_DONE:  state_reg <= mdq_pkg::MDQ_ST_IDLE;
        mdq_pkg::MDQ_ST_EXIT:  state_reg <= mdq_pkg::MDQ_ST_IDLE;
        default:               state_reg <= mdq_pkg::MDQ_ST_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // request capture
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      op_reg      <= mdq_pkg::MDQ_OP_TEST;
      xfer_reg    <= 1'b0;
      phys_reg    <= 1'b0;
      cb_seg_reg  <= 12'h000;
      cb_addr_reg <= `MDQ_WORD_RST;
    end else if (state_reg == mdq_pkg::MDQ_ST_IDLE) begin
      if (in_req || out_req) begin
        op_reg      <= in_req ? mdq_pkg::MDQ_OP_ADD_BOTTOM : mdq_pkg::MDQ_OP_REM_TOP;
        xfer_reg    <= 1'b1;
        phys_reg    <= 1'b1;
        cb_seg_reg  <= 12'h000;
        cb_addr_reg <= peripheral_address_bus_i;
      end else if (op_req) begin
        op_reg      <= mdq_pkg::mdq_op_e'(op_code_i);
        xfer_reg    <= 1'b0;
        phys_reg    <= op_physical_i;
        cb_seg_reg  <= op_segment_i;
        cb_addr_reg <= argument_pointer_word_i;
      end
    end
  end

  // --------------------------------------------------------------------------
  // control words, datum, new pointer and end-of-range
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      top_reg     <= `MDQ_WORD_RST;
      bot_reg     <= `MDQ_WORD_RST;
      seg_reg     <= `MDQ_WORD_RST;
      mask_reg    <= `MDQ_WORD_RST;
      data_reg    <= `MDQ_WORD_RST;
      new_ptr_reg <= `MDQ_WORD_RST;
      eor_reg     <= 1'b0;
    end else if (state_reg == mdq_pkg::MDQ_ST_IDLE) begin
      data_reg <= in_req ? xfer_wdata_i : acc_i;
      eor_reg  <= 1'b0;
    end else if (mem_ack_i) begin
      unique case (state_reg)
        mdq_pkg::MDQ_ST_RTOP: top_reg <= mem_rdata_i;
        mdq_pkg::MDQ_ST_RBOT: begin
          bot_reg <= mem_rdata_i;
          if (!op_is_add(op_reg) && mem_rdata_i == top_reg) begin
            data_reg <= `MDQ_WORD_RST;
            eor_reg  <= (op_reg != mdq_pkg::MDQ_OP_TEST);
          end
        end
        mdq_pkg::MDQ_ST_RSEG:  seg_reg <= mem_rdata_i;
        mdq_pkg::MDQ_ST_RMASK: begin
          mask_reg <= mem_rdata_i;
          if (op_reg == mdq_pkg::MDQ_OP_ADD_BOTTOM) begin
            new_ptr_reg <= 16'((bot_reg & ~mem_rdata_i) | (16'(bot_reg + 16'h0001) & mem_rdata_i));
            eor_reg     <= (16'((bot_reg & ~mem_rdata_i) | (16'(bot_reg + 16'h0001) & mem_rdata_i))
                            == top_reg);
          end else if (op_reg == mdq_pkg::MDQ_OP_ADD_TOP) begin
            new_ptr_reg <= 16'((top_reg & ~mem_rdata_i) | (16'(top_reg - 16'h0001) & mem_rdata_i));
            eor_reg     <= (16'((top_reg & ~mem_rdata_i) | (16'(top_reg - 16'h0001) & mem_rdata_i))
                            == bot_reg);
          end
        end
        mdq_pkg::MDQ_ST_DATA: begin
          if (op_reg == mdq_pkg::MDQ_OP_REM_TOP) begin
            data_reg    <= mem_rdata_i;
            new_ptr_reg <= top_inc;
          end else if (op_reg == mdq_pkg::MDQ_OP_REM_BOTTOM) begin
            data_reg    <= mem_rdata_i;
            new_ptr_reg <= bot_dec;
          end
        end
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // memory request generation, all uncached
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      mem_req_o      <= 1'b0;
      mem_we_o       <= 1'b0;
      mem_addr_o     <= 28'h0000000;
      mem_wdata_o    <= `MDQ_WORD_RST;
      mem_uncached_o <= 1'b1;
      mem_ring_o     <= `MDQ_RING_PRIV;
    end else begin
      mem_uncached_o <= 1'b1;
      if (mem_wait) begin
        mem_req_o <= 1'b1;
      end else begin
        mem_req_o <= 1'b0;
        mem_we_o  <= 1'b0;
        unique case (state_reg)
          mdq_pkg::MDQ_ST_IDLE: begin
            if (in_req || out_req || (op_req && !(op_physical_i && ring_i != `MDQ_RING_PRIV))) begin
              mem_req_o  <= 1'b1;
              mem_addr_o <= {(in_req || out_req) ? 12'h000 : op_segment_i,
                             (in_req || out_req) ? peripheral_address_bus_i : argument_pointer_word_i};
              mem_ring_o <= (in_req || out_req) ? `MDQ_RING_PRIV : ring_i;
            end
          end
          mdq_pkg::MDQ_ST_RTOP: begin
            mem_req_o  <= 1'b1;
            mem_addr_o <= {cb_seg_reg, 16'(cb_addr_reg + {14'h0000, `MDQ_CB_BOTTOM})};
          end
          mdq_pkg::MDQ_ST_RBOT: begin
            if (op_is_add(op_reg) || mem_rdata_i != top_reg) begin
              mem_req_o  <= 1'b1;
              mem_addr_o <= {cb_seg_reg, 16'(cb_addr_reg + {14'h0000, `MDQ_CB_SEGMENT})};
            end
          end
          mdq_pkg::MDQ_ST_RSEG: begin
            mem_req_o  <= 1'b1;
            mem_addr_o <= {cb_seg_reg, 16'(cb_addr_reg + {14'h0000, `MDQ_CB_MASK})};
          end
          mdq_pkg::MDQ_ST_RMASK: begin
            // data cell: physical uses six extension bits, virtual a segment
            if (op_reg != mdq_pkg::MDQ_OP_TEST) begin
              // a full add leaves memory untouched and exits
              mem_req_o <= !(op_reg == mdq_pkg::MDQ_OP_ADD_BOTTOM &&
                             16'((bot_reg & ~mem_rdata_i) | (16'(bot_reg + 16'h0001) & mem_rdata_i)) == top_reg) &&
                           !(op_reg == mdq_pkg::MDQ_OP_ADD_TOP &&
                             16'((top_reg & ~mem_rdata_i) | (16'(top_reg - 16'h0001) & mem_rdata_i)) == bot_reg);
              mem_we_o  <= op_is_add(op_reg);
              mem_wdata_o <= data_reg;
              mem_addr_o  <= {phys_reg ? {6'h00, seg_reg[`MDQ_EXT_W-1:0]} : seg_reg[`MDQ_SEG_W-1:0],
                              op_reg == mdq_pkg::MDQ_OP_ADD_BOTTOM ? bot_reg :
                              op_reg == mdq_pkg::MDQ_OP_REM_TOP    ? top_reg :
                              op_reg == mdq_pkg::MDQ_OP_REM_BOTTOM ?
                                16'((bot_reg & ~mem_rdata_i) | (16'(bot_reg - 16'h0001) & mem_rdata_i)) :
                                16'((top_reg & ~mem_rdata_i) | (16'(top_reg - 16'h0001) & mem_rdata_i))};
            end
          end
          mdq_pkg::MDQ_ST_DATA: begin
            // pointer store only after the datum is written or read
            if (!eor_reg) begin
              mem_req_o  <= 1'b1;
              mem_we_o   <= 1'b1;
              mem_addr_o <= {cb_seg_reg, 16'(cb_addr_reg + {14'h0000,
                             (op_reg == mdq_pkg::MDQ_OP_REM_TOP || op_reg == mdq_pkg::MDQ_OP_ADD_TOP) ?
                             `MDQ_CB_TOP : `MDQ_CB_BOTTOM})};
              mem_wdata_o <= (op_reg == mdq_pkg::MDQ_OP_REM_TOP) ? top_inc :
                             (op_reg == mdq_pkg::MDQ_OP_REM_BOTTOM) ? bot_dec : new_ptr_reg;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // completion: acknowledge, accumulator and condition codes
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      xfer_ack_o               <= 1'b0;
      in_end_of_range_signal_o <= 1'b0;
      op_done_o                <= 1'b0;
      acc_o                    <= `MDQ_WORD_RST;
      cond_code_o              <= 3'h0;
    end else begin
      xfer_ack_o <= 1'b0;
      op_done_o  <= 1'b0;
      if (state_reg == mdq_pkg::MDQ_ST_DONE) begin
        if (xfer_reg) begin
          xfer_ack_o               <= 1'b1;
          in_end_of_range_signal_o <= op_is_add(op_reg) && eor_reg;
        end else begin
          op_done_o <= 1'b1;
          if (!op_is_add(op_reg) && op_reg != mdq_pkg::MDQ_OP_TEST) begin
            acc_o <= data_reg;
          end
          cond_code_o[`MDQ_CC_EMPTY] <= (op_reg == mdq_pkg::MDQ_OP_TEST) ? (q_len == 16'h0000 || q_empty)
                                        : (!op_is_add(op_reg) && eor_reg);
          cond_code_o[`MDQ_CC_FULL]  <= (op_reg == mdq_pkg::MDQ_OP_TEST) ? (q_len == mask_reg && !q_empty)
                                        : (op_is_add(op_reg) && eor_reg);
          cond_code_o[`MDQ_CC_FAULT] <= 1'b0;
        end
      end else if (state_reg == mdq_pkg::MDQ_ST_EXIT) begin
        op_done_o                  <= 1'b1;
        cond_code_o                <= 3'h0;
        cond_code_o[`MDQ_CC_FAULT] <= 1'b1;
      end
    end
  end

endmodule

/* rtl/mdq_defs.svh */
// constants of the memory deque engine
`ifndef MDQ_DEFS_SVH
`define MDQ_DEFS_SVH

// --------------------------------------------------------------------------
// control block word offsets
// --------------------------------------------------------------------------
`define MDQ_CB_TOP      2'h0
`define MDQ_CB_BOTTOM   2'h1
`define MDQ_CB_SEGMENT  2'h2
`define MDQ_CB_MASK     2'h3

// --------------------------------------------------------------------------
// request mode codes and field positions
// --------------------------------------------------------------------------
`define MDQ_MODE_IN     5'h01
`define MDQ_MODE_OUT    5'h00
`define MDQ_EXT_LSB     16
`define MDQ_EXT_W       6
`define MDQ_SEG_W       12

// --------------------------------------------------------------------------
// condition code bits and reset values
// --------------------------------------------------------------------------
`define MDQ_CC_EMPTY    0
`define MDQ_CC_FULL     1
`define MDQ_CC_FAULT    2
`define MDQ_WORD_RST    16'h0000
`define MDQ_RING_PRIV   2'h0

`endif

/* rtl/mdq_pkg.sv */
// types of the memory deque engine
package mdq_pkg;

  // --------------------------------------------------------------------------
  // queue operations and sequencer states
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    MDQ_OP_ADD_TOP    = 3'h0,
    MDQ_OP_ADD_BOTTOM = 3'h1,
    MDQ_OP_REM_TOP    = 3'h2,
    MDQ_OP_REM_BOTTOM = 3'h3,
    MDQ_OP_TEST       = 3'h4
  } mdq_op_e;

  typedef enum logic [8:0] {
    MDQ_ST_IDLE  = 9'h001,
    MDQ_ST_RTOP  = 9'h002,
    MDQ_ST_RBOT  = 9'h004,
    MDQ_ST_RSEG  = 9'h008,
    MDQ_ST_RMASK = 9'h010,
    MDQ_ST_DATA  = 9'h020,
    MDQ_ST_WPTR  = 9'h040,
    MDQ_ST_DONE  = 9'h080,
    MDQ_ST_EXIT  = 9'h100
  } mdq_state_e;

endpackage

/* rtl/mdq_ptr_calc.sv */
// mask based pointer arithmetic of a queue
`timescale 1ns/100ps
`include "mdq_defs.svh"

module mdq_ptr_calc (
  // pointers and mask
  input  wire logic [15:0] top_i,
  input  wire logic [15:0] bottom_i,
  input  wire logic [15:0] mask_i,
  // results
  output logic      [15:0] top_inc_o,
  output logic      [15:0] top_dec_o,
  output logic      [15:0] bot_inc_o,
  output logic      [15:0] bot_dec_o,
  output logic      [15:0] origin_o,
  output logic      [15:0] end_o,
  output logic             empty_o,
  output logic             full_o,
  output logic      [15:0] length_o
);

  // steps a pointer only within the bits chosen by the mask
  function automatic logic [15:0] wrap_step(input logic [15:0] p, input logic [15:0] m, input logic up);
    logic [15:0] s;
    s = up ? 16'(p + 16'h0001) : 16'(p - 16'h0001);
    return (p & ~m) | (s & m);
  endfunction

  // wrapped steps of both pointers
  assign top_inc_o = wrap_step(top_i, mask_i, 1'b1);
  assign top_dec_o = wrap_step(top_i, mask_i, 1'b0);
  assign bot_inc_o = wrap_step(bottom_i, mask_i, 1'b1);
  assign bot_dec_o = wrap_step(bottom_i, mask_i, 1'b0);

  // block bounds from any pointer inside it
  assign origin_o = bottom_i & ~mask_i;
  assign end_o    = bottom_i | mask_i;

  // occupancy, empty and full
  assign length_o = 16'(bottom_i - top_i) & mask_i;
  assign empty_o  = (top_i == bottom_i);
  assign full_o   = (bot_inc_o == top_i);

endmodule

/* rtl/mdq_skid_buf.sv */
// two-entry valid/ready buffer for output words
`timescale 1ns/100ps

module mdq_skid_buf (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        srst_i,
  // filling side
  input  wire logic        in_valid_i,
  output logic             in_ready_o,
  input  wire logic [16:0] in_data_i,
  // draining side
  output logic             out_valid_o,
  input  wire logic        out_ready_i,
  output logic      [16:0] out_data_o
);

  logic [16:0] mem_reg [0:1];
  logic        wr_idx_reg;
  logic        rd_idx_reg;
  logic [1:0]  count_reg;
  logic        push;
  logic        pop;

  // handshakes on both sides
  assign push        = in_valid_i && (count_reg != 2'h2);
  assign pop         = out_ready_i && (count_reg != 2'h0);
  assign in_ready_o  = (count_reg != 2'h2);
  assign out_valid_o = (count_reg != 2'h0);
  assign out_data_o  = mem_reg[rd_idx_reg];

  // storage, written by index
  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem_reg[wr_idx_reg] <= in_data_i;
    end
  end

  // pointers and fill count
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      wr_idx_reg <= 1'b0;
      rd_idx_reg <= 1'b0;
      count_reg  <= 2'h0;
    end else begin
      if (push) begin
        wr_idx_reg <= ~wr_idx_reg;
      end
      if (pop) begin
        rd_idx_reg <= ~rd_idx_reg;
      end
      count_reg <= 2'(count_reg + {1'b0, push} - {1'b0, pop});
    end
  end

endmodule

/* dv/mdq_mem_model.sv */
// uncached main memory seen by the engine's memory port
`timescale 1ns/100ps

module mdq_mem_model (
  // clock
  input  wire logic        mclk_i,
  // request side
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] wdata_i,
  // answer side
  output logic             ack_o,
  output logic      [15:0] rdata_o
);
  logic [15:0] mem [0:65535];

  initial begin
    ack_o   = 1'b0;
    rdata_o = 16'h0000;
  end

  // one-cycle ack pulse; a released read bus toggles so stale data never matches
  always @(posedge mclk_i) begin
    ack_o   <= req_i && !ack_o;
    rdata_o <= ~rdata_o;
    if (req_i && !ack_o && we_i) mem[addr_i] <= wdata_i;
    if (req_i && !ack_o && !we_i) rdata_o <= mem[addr_i];
  end
endmodule

/* dv/mdq_engine_sva.sv */
// assertion checker for the memory deque engine ports
`timescale 1ns/100ps

module mdq_engine_sva (
  // clock and reset
  input wire logic        mclk_i,
  input wire logic        srst_i,
  // transfer side
  input wire logic        direct_transfer_request_i,
  input wire logic        xfer_ack_o,
  input wire logic        out_valid_o,
  input wire logic        out_ready_i,
  input wire logic [15:0] out_data_o,
  input wire logic        out_end_of_range_signal_o,
  // instruction side
  input wire logic        op_physical_i,
  input wire logic [1:0]  ring_i,
  input wire logic        op_done_o,
  input wire logic [2:0]  cond_code_o,
  // memory side
  input wire logic        mem_req_o,
  input wire logic        mem_ack_i,
  input wire logic [27:0] mem_addr_o,
  input wire logic        mem_uncached_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  a_cache_bypass: assert property (mem_uncached_o)
    else $error("memory access not marked uncached");
  a_mem_req_holds: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o))
    else $error("memory request dropped or moved before ack");
  a_ack_is_pulse: assert property (xfer_ack_o |=> !xfer_ack_o)
    else $error("transfer ack longer than one cycle");
  a_done_is_pulse: assert property (op_done_o |=> !op_done_o)
    else $error("instruction done longer than one cycle");
  a_ring_fault: assert property (op_done_o && cond_code_o[2] |-> op_physical_i && ring_i != 2'h0)
    else $error("privilege fault without physical queue in outer ring");
  a_empty_word_zero: assert property (out_valid_o && out_end_of_range_signal_o |-> out_data_o == 16'h0000)
    else $error("end-of-range word not zero");
  a_stall_holds: assert property (out_valid_o && !out_ready_i |=>
    out_valid_o && $stable(out_data_o) && $stable(out_end_of_range_signal_o))
    else $error("output word changed while stalled");
  a_xfer_answer: assert property ($rose(direct_transfer_request_i) |-> ##[4:60] xfer_ack_o)
    else $error("transfer not answered in time");

  // main scenarios reached
  cover property (xfer_ack_o);
  cover property (out_valid_o && out_end_of_range_signal_o);
  cover property (op_done_o && cond_code_o[2]);
endmodule

bind mdq_engine mdq_engine_sva u_mdq_engine_sva (.mclk_i, .srst_i, .direct_transfer_request_i, .xfer_ack_o,
  .out_valid_o, .out_ready_i, .out_data_o, .out_end_of_range_signal_o, .op_physical_i, .ring_i, .op_done_o,
  .cond_code_o, .mem_req_o, .mem_ack_i, .mem_addr_o, .mem_uncached_o);

/* dv/memory_deque_engine_tb.sv */
// self-checking bench of the memory deque engine
`timescale 1ns/100ps

module memory_deque_engine_tb;
  logic        mclk_i = 1'b0, srst_i, direct_transfer_request_i, xfer_ack_o, out_valid_o, out_ready_i;
  logic        out_end_of_range_signal_o, in_end_of_range_signal_o, op_valid_i, op_physical_i, op_done_o;
  logic        mem_req_o, mem_we_o, mem_uncached_o, mem_ack_i;
  logic [4:0]  request_mode_code_i;
  logic [2:0]  op_code_i, cond_code_o, got_cc;
  logic [1:0]  ring_i, mem_ring_o;
  logic [11:0] op_segment_i;
  logic [27:0] mem_addr_o;
  logic [15:0] peripheral_address_bus_i, xfer_wdata_i, out_data_o, argument_pointer_word_i, acc_i, acc_o;
  logic [15:0] mem_wdata_o, mem_rdata_i, got_acc;
  logic [16:0] outq[$];
  int          miscompares = 0, compares = 0;

  mdq_engine u_mdq_engine (.*);
  mdq_mem_model u_mdq_mem_model (.mclk_i, .req_i(mem_req_o), .we_i(mem_we_o), .addr_i(mem_addr_o[15:0]),
    .wdata_i(mem_wdata_o), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));

  // clock and output word collector
  initial forever #12.5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) if (out_valid_o === 1'b1 && out_ready_i) outq.push_back({out_end_of_range_signal_o, out_data_o});

  task chk(input logic [16:0] g, input logic [16:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task summarize;
    if (miscompares == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // one transfer or instruction: hold the request until its answer edge
  task go(input bit o, input logic [4:0] m, input logic [2:0] c, input logic [15:0] d, input logic [1:0] r);
    int n;
    n = 0;
    op_valid_i <= o;
    direct_transfer_request_i <= !o;
    request_mode_code_i <= m;
    op_code_i <= c;
    acc_i <= d;
    xfer_wdata_i <= d;
    ring_i <= r;
    do begin
      @(posedge mclk_i);
      n++;
    end while ((o ? op_done_o : xfer_ack_o) !== 1'b1 && n < 200);
    got_acc = acc_o;
    got_cc = cond_code_o;
    chk(n < 200, 17'h1);
    op_valid_i <= 1'b0;
    direct_transfer_request_i <= 1'b0;
    @(posedge mclk_i);
  endtask

  // empty queue at 16'h0100, 16 words, both pointers at p
  task setq(input logic [15:0] p);
    u_mdq_mem_model.mem[16'h0010] = p;
    u_mdq_mem_model.mem[16'h0011] = p;
    u_mdq_mem_model.mem[16'h0012] = 16'h0000;
    u_mdq_mem_model.mem[16'h0013] = 16'h000f;
  endtask

  task t_fill;
    setq(16'h010c);
    u_mdq_mem_model.mem[16'h010b] = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      go(1'b0, 5'h01, 3'h0, 16'h0a00 + i[15:0], 2'h0);
      chk(in_end_of_range_signal_o, i == 15);
    end
    chk(u_mdq_mem_model.mem[16'h0011], 16'h010b);
    chk(u_mdq_mem_model.mem[16'h0100], 16'h0a04);
    chk(u_mdq_mem_model.mem[16'h010b], 16'h0000);
  endtask

  task t_drain;
    out_ready_i <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      if (i == 2) out_ready_i <= 1'b1;
      go(1'b0, 5'h00, 3'h0, 16'h0000, 2'h0);
    end
    repeat (4) @(posedge mclk_i);
    chk(outq.size(), 17'h10);
    for (int i = 0; i < 16; i++) chk(outq[i], i < 15 ? 17'h00a00 + i : 17'h10000);
    chk(u_mdq_mem_model.mem[16'h0010], 16'h010b);
  endtask

  task t_ops;
    setq(16'h0100);
    go(1'b1, 5'h00, 3'h0, 16'haaaa, 2'h0);
    chk(u_mdq_mem_model.mem[16'h010f], 16'haaaa);
    go(1'b1, 5'h00, 3'h4, 16'h0000, 2'h0);
    chk(got_cc, 3'h0);
    go(1'b1, 5'h00, 3'h3, 16'h0000, 2'h0);
    chk(got_acc, 16'haaaa);
    go(1'b1, 5'h00, 3'h2, 16'h0000, 2'h0);
    chk(got_cc, 3'h1);
    go(1'b1, 5'h00, 3'h1, 16'h5555, 2'h0);
    go(1'b1, 5'h00, 3'h2, 16'h0000, 2'h0);
    chk(got_acc, 16'h5555);
    go(1'b1, 5'h00, 3'h2, 16'h0000, 2'h1);
    chk(got_cc[2], 1'b1);
  endtask

  // main sequence
  initial begin
    srst_i = 1'b1;
    {direct_transfer_request_i, op_valid_i, request_mode_code_i, op_code_i, ring_i} = '0;
    {xfer_wdata_i, acc_i, op_segment_i} = '0;
    out_ready_i = 1'b1;
    op_physical_i = 1'b1;
    peripheral_address_bus_i = 16'h0010;
    argument_pointer_word_i = 16'h0010;
    repeat (8) @(posedge mclk_i);
    srst_i <= 1'b0;
    t_fill;
    t_drain;
    t_ops;
    summarize;
  end

  // watchdog: the run needs well under 2000 cycles
  initial begin
    #100us;
    miscompares++;
    summarize;
  end
endmodule
